// >>> logic/rtc_i2c_slave_test_logic.sv
`timescale 1ns/100ps
`include "rtc_consts.svh"

module rtc_i2c_slave_test_logic
	import rtc_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A, // Arbitrary value.
	parameter int POR_CYCLES = `RTC_POR_CYCLES
)
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic clock_output_pin_i,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_o,
	input wire logic int_tick_i,
	input wire logic override_seq_i,
	output logic sec_inc_o,
	output logic por_active_o,
	output logic override_mode_o,
	output logic external_tick_mode_o
);

	localparam int POR_W = $clog2(POR_CYCLES + 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------

	// Two stages for each pin, then one more stage for edge finding.
	logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
	logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
	logic ck_meta_reg, ck_sync_reg, ck_prev_reg;
	logic ovr_meta_reg, ovr_sync_reg, ovr_prev_reg;

	// Logic reads the second and third stages, never the first.
	always_ff @(posedge core_clk_i)
	begin
		scl_meta_reg <= scl_i;
		scl_sync_reg <= scl_meta_reg;
		scl_prev_reg <= scl_sync_reg;
		sda_meta_reg <= sda_i;
		sda_sync_reg <= sda_meta_reg;
		sda_prev_reg <= sda_sync_reg;
		ck_meta_reg <= clock_output_pin_i;
		ck_sync_reg <= ck_meta_reg;
		ck_prev_reg <= ck_sync_reg;
		ovr_meta_reg <= override_seq_i;
		ovr_sync_reg <= ovr_meta_reg;
		ovr_prev_reg <= ovr_sync_reg;
	end

	// Bus edges and conditions.
	wire scl_rise = scl_sync_reg & ~scl_prev_reg;
	wire scl_fall = ~scl_sync_reg & scl_prev_reg;
	wire scl_high = scl_sync_reg & scl_prev_reg;
	wire start_det = scl_high & sda_prev_reg & ~sda_sync_reg;
	wire stop_det = scl_high & ~sda_prev_reg & sda_sync_reg;
	wire ck_rise = ck_sync_reg & ~ck_prev_reg;
	wire ovr_rise = ovr_sync_reg & ~ovr_prev_reg;

	// -----------------------------------------------------------------
	// State declarations
	// -----------------------------------------------------------------

	rtc_state_e state_reg, state_next; // Slave sequencer.
	logic [3:0] cnt_reg, cnt_next; // Bits of the current byte.
	rtc_byte_t shift_reg, shift_next; // Receive and transmit shifter.
	logic [3:0] ptr_reg, ptr_next; // Register pointer.
	logic rw_reg, rw_next; // Set for a read transfer.
	logic nack_reg, nack_next; // Master answer to a read byte.
	logic sda_o_reg, sda_o_next; // Data line level.
	logic sda_oe_reg, sda_oe_next; // Data line drive.
	logic test_reg, test_next; // External tick mode.
	logic hold_reg, hold_next; // Pre-scaler hold.
	logic permit_reg, permit_next; // Override permit.
	rtc_byte_t sec_reg, sec_next; // Seconds count.
	rtc_byte_t mem_reg [16]; // Plain storage for other pointers.
	logic [5:0] presc_reg, presc_next; // Pre-scaler chain.
	logic sec_inc_reg, sec_inc_next; // One-second pulse.
	logic [POR_W-1:0] por_cnt_reg; // Power-up reset timer.
	logic por_active_reg; // Power-up reset in force.
	logic ovr_mode_reg; // Override mode entered.
	logic ck_o_reg; // Clock pin drive level.
	logic ck_oe_reg; // Clock pin drive enable.

	// -----------------------------------------------------------------
	// Register access decode
	// -----------------------------------------------------------------

	// A write lands when the last data bit is in, on the next clock fall.
	wire byte_end = scl_fall & (cnt_reg == `RTC_BYTE_BITS);
	wire bit_in = scl_rise & (cnt_reg != `RTC_BYTE_BITS);
	wire wr_stb = (state_reg == ST_WR) & byte_end;
	wire wr_ctrl = wr_stb & (ptr_reg == `RTC_OFS_CTRL1);
	wire wr_sec = wr_stb & (ptr_reg == `RTC_OFS_SECONDS);
	wire rx_state = (state_reg == ST_ADDR) | (state_reg == ST_PTR) | (state_reg == ST_WR);
	wire addr_hit = (shift_reg[7:1] == SLAVE_ADDR) & ~por_active_reg;

	// Read view of the control register; unused bits read zero.
	wire rtc_byte_t ctrl_rd = {test_reg, 1'b0, hold_reg, 1'b0, permit_reg, 3'b000};
	wire is_ctrl = (ptr_reg == `RTC_OFS_CTRL1);
	wire is_sec = (ptr_reg == `RTC_OFS_SECONDS);
	wire rtc_byte_t rd_data = is_ctrl ? ctrl_rd : (is_sec ? sec_reg : mem_reg[ptr_reg]);

	// Tick source and pre-scaler terms.
	// tick source select
	wire tick = test_reg ? ck_rise : int_tick_i;
	wire presc_wrap = tick & ~hold_reg & (presc_reg == `RTC_PRESC_FIRST);
	wire sec_top = (sec_reg == `RTC_SECONDS_MAX);
	wire ovr_enter = ovr_rise & permit_reg & ~ovr_mode_reg;

	// -----------------------------------------------------------------
	// Serial slave sequencer
	// -----------------------------------------------------------------

	// The slave only samples the clock line and never drives it.
	// slave only
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		rw_next = rw_reg;
		nack_next = nack_reg;
		sda_o_next = sda_o_reg;
		sda_oe_next = sda_oe_reg;
		if (stop_det)
		begin
			// A stop always frees the line and ends the transfer.
			state_next = ST_IDLE;
			sda_o_next = 1'b1;
			sda_oe_next = 1'b0;
		end
		else if (start_det)
		begin
			state_next = ST_ADDR;
			cnt_next = 4'h0;
			sda_o_next = 1'b1;
			sda_oe_next = 1'b0;
		end
		else if (rx_state & bit_in)
		begin
			shift_next = {shift_reg[6:0], sda_sync_reg};
			cnt_next = cnt_reg + 4'h1;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					// Waiting for a start; the line stays released.
					sda_oe_next = 1'b0;
				end
				ST_ADDR:
				begin
					if (byte_end)
					begin
						cnt_next = 4'h0;
						// A foreign address, or one during power-up reset, is ignored.
						if (addr_hit)
						begin
							rw_next = shift_reg[0];
							state_next = ST_ADDR_ACK;
							sda_o_next = 1'b0;
							sda_oe_next = 1'b1;
						end
						else
						begin
							state_next = ST_IDLE;
						end
					end
				end
				ST_PTR:
				begin
					if (byte_end)
					begin
						ptr_next = shift_reg[3:0];
						cnt_next = 4'h0;
						state_next = ST_PTR_ACK;
						sda_o_next = 1'b0;
						sda_oe_next = 1'b1;
					end
				end
				ST_WR:
				begin
					if (byte_end)
					begin
						ptr_next = ptr_reg + 4'h1;
						cnt_next = 4'h0;
						state_next = ST_WR_ACK;
						sda_o_next = 1'b0;
						sda_oe_next = 1'b1;
					end
				end
				ST_ADDR_ACK, ST_RD_ACK:
				begin
					if (scl_rise & (state_reg == ST_RD_ACK))
					begin
						nack_next = sda_sync_reg;
					end
					else if (scl_fall)
					begin
						cnt_next = 4'h1;
						if ((state_reg == ST_ADDR_ACK) & ~rw_reg)
						begin
							state_next = ST_PTR;
							cnt_next = 4'h0;
							sda_o_next = 1'b1;
							sda_oe_next = 1'b0;
						end
						else if ((state_reg == ST_RD_ACK) & nack_reg)
						begin
							state_next = ST_IDLE;
							sda_o_next = 1'b1;
							sda_oe_next = 1'b0;
						end
						else
						begin
							// First bit out right away; a one is a released line.
							state_next = ST_RD;
							shift_next = {rd_data[6:0], 1'b0};
							sda_o_next = rd_data[7];
							sda_oe_next = ~rd_data[7];
						end
					end
				end
				ST_PTR_ACK, ST_WR_ACK:
				begin
					if (scl_fall)
					begin
						state_next = ST_WR;
						sda_o_next = 1'b1;
						sda_oe_next = 1'b0;
					end
				end
				ST_RD:
				begin
					if (scl_fall & (cnt_reg != `RTC_BYTE_BITS))
					begin
						sda_o_next = shift_reg[7];
						sda_oe_next = ~shift_reg[7];
						shift_next = {shift_reg[6:0], 1'b0};
						cnt_next = cnt_reg + 4'h1;
					end
					else if (byte_end)
					begin
						ptr_next = ptr_reg + 4'h1;
						cnt_next = 4'h0;
						nack_next = 1'b1;
						state_next = ST_RD_ACK;
						sda_o_next = 1'b1;
						sda_oe_next = 1'b0;
					end
				end
				default:
				begin
					state_next = ST_IDLE;
					sda_oe_next = 1'b0;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Control, seconds and pre-scaler next values
	// -----------------------------------------------------------------

	assign test_next = wr_ctrl ? shift_reg[`RTC_BIT_TEST] : test_reg;
	assign hold_next = wr_ctrl ? shift_reg[`RTC_BIT_HOLD] : hold_reg;
	assign permit_next = wr_ctrl ? shift_reg[`RTC_BIT_PERMIT] : permit_reg;
	// A load from the bus wins over a tick in the same cycle.
	assign sec_next = wr_sec ? shift_reg : (sec_inc_reg ? (sec_top ? `RTC_SECONDS_RST : sec_reg + 8'h01) : sec_reg);
	assign presc_next = hold_reg ? 6'h00 : (tick ? presc_reg + 6'h01 : presc_reg);
	assign sec_inc_next = presc_wrap;

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------

	// Sequencer and line drive.
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= `RTC_BYTE_RST;
			ptr_reg <= 4'h0;
			rw_reg <= 1'b0;
			nack_reg <= 1'b1;
			sda_o_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			rw_reg <= rw_next;
			nack_reg <= nack_next;
			sda_o_reg <= sda_o_next;
			sda_oe_reg <= sda_oe_next;
		end
	end

	// Control bits, seconds and pre-scaler.
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			test_reg <= `RTC_TEST_RST;
			hold_reg <= `RTC_HOLD_RST;
			permit_reg <= `RTC_PERMIT_RST;
			sec_reg <= `RTC_SECONDS_RST;
			presc_reg <= 6'h00;
			sec_inc_reg <= 1'b0;
		end
		else
		begin
			test_reg <= test_next;
			hold_reg <= hold_next;
			permit_reg <= permit_next;
			sec_reg <= sec_next;
			presc_reg <= presc_next;
			sec_inc_reg <= sec_inc_next;
		end
	end

	// Plain storage for pointers without behaviour of their own.
	always_ff @(posedge core_clk_i)
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (srst_i)
				mem_reg[i] <= `RTC_BYTE_RST;
			else if (wr_stb & (ptr_reg == 4'(i)))
				mem_reg[i] <= shift_reg;
		end
	end

	// Power-up reset timer; the override cuts it short at once.
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			por_cnt_reg <= '0;
			por_active_reg <= 1'b1;
		end
		else if (ovr_enter)
			por_active_reg <= 1'b0;
		else if (por_active_reg)
		begin
			por_cnt_reg <= por_cnt_reg + POR_W'(1);
			por_active_reg <= (por_cnt_reg != POR_LAST);
		end
	end

	// Override mode flag; the bus write that clears the permit ends it.
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			ovr_mode_reg <= 1'b0;
		else if (ovr_enter)
			ovr_mode_reg <= 1'b1;
		else if (wr_ctrl & ~shift_reg[`RTC_BIT_PERMIT])
			ovr_mode_reg <= 1'b0;
	end

	// In normal mode the pin carries the tick divided by two.
	// pin becomes input
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			ck_o_reg <= 1'b0;
			ck_oe_reg <= 1'b1;
		end
		else
		begin
			ck_o_reg <= presc_reg[0];
			ck_oe_reg <= ~test_next;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------

	assign sda_o = sda_o_reg;
	assign sda_oe_o = sda_oe_reg;
	assign clock_output_pin_o = ck_o_reg;
	assign clock_output_pin_oe_o = ck_oe_reg;
	assign sec_inc_o = sec_inc_reg;
	assign por_active_o = por_active_reg;
	assign override_mode_o = ovr_mode_reg;
	assign external_tick_mode_o = test_reg;

endmodule

// >>> logic/rtc_consts.svh
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
// Register pointer values.
`define RTC_OFS_CTRL1 4'h0
`define RTC_OFS_SECONDS 4'h2
// Field positions in the first control register.
`define RTC_BIT_TEST 7
`define RTC_BIT_HOLD 5
`define RTC_BIT_PERMIT 3
// Reset values.
`define RTC_TEST_RST 1'b0
`define RTC_HOLD_RST 1'b0
`define RTC_PERMIT_RST 1'b1
`define RTC_SECONDS_RST 8'h00
`define RTC_BYTE_RST 8'h00
// Counts.
`define RTC_BYTE_BITS 4'h8
`define RTC_PRESC_FIRST 6'h1F
`define RTC_SECONDS_MAX 8'h3B
// Timing.
`define RTC_CLK_MHZ 100
`define RTC_POR_TIME_US 2000
`define RTC_POR_CYCLES (`RTC_POR_TIME_US * `RTC_CLK_MHZ)
`endif

// >>> logic/rtc_pkg.sv
package rtc_pkg;

	// Serial slave states.
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_PTR = 4'h3,
		ST_PTR_ACK = 4'h4,
		ST_WR = 4'h5,
		ST_WR_ACK = 4'h6,
		ST_RD = 4'h7,
		ST_RD_ACK = 4'h8
	} rtc_state_e;

	// One register byte.
	typedef logic [7:0] rtc_byte_t;

endpackage

// >>> verif/rtc_props_properties.sv
`timescale 1ns/100ps
// ----
// Port checks of the serial slave.
// ----
module rtc_props
#(
	parameter int POR_CYCLES = 50
)
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic clock_output_pin_oe_o,
	input wire logic override_seq_i,
	input wire logic sec_inc_o,
	input wire logic por_active_o,
	input wire logic override_mode_o,
	input wire logic external_tick_mode_o
);
	// Cycles spent in power-up reset; bounds the hold time.
	int por_cnt;

	// Count only while reset holds, so a late release is caught.
	always_ff @(posedge core_clk_i)
	begin
		por_cnt <= (srst_i || !por_active_o) ? 0 : por_cnt + 1;
	end

	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	sda_low_only_a: assert property (sda_oe_o |-> !sda_o) else $error("sda driven high");
	ack_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("sda moved, scl high");
	test_pin_in_a: assert property ($past(external_tick_mode_o) && external_tick_mode_o |-> !clock_output_pin_oe_o)
		else $error("clock pin driven in test mode");
	sec_pulse_a: assert property (sec_inc_o |=> (!sec_inc_o) [*8]) else $error("seconds pulse too close");
	por_release_a: assert property ($rose(override_seq_i) && por_active_o |-> ##[1:8] !por_active_o)
		else $error("override did not release reset");
	por_stays_off_a: assert property (!por_active_o |=> !por_active_o) else $error("reset reasserted");
	mode_with_por_a: assert property ($rose(override_mode_o) |-> ##[0:4] !por_active_o)
		else $error("override mode kept reset");
	por_limit_a: assert property (por_active_o |-> por_cnt <= POR_CYCLES + 4) else $error("reset held too long");
endmodule

bind rtc_i2c_slave_test_logic rtc_props #(.POR_CYCLES(POR_CYCLES)) u_props (
	.core_clk_i(core_clk_i),
	.srst_i(srst_i),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.clock_output_pin_oe_o(clock_output_pin_oe_o),
	.override_seq_i(override_seq_i),
	.sec_inc_o(sec_inc_o),
	.por_active_o(por_active_o),
	.override_mode_o(override_mode_o),
	.external_tick_mode_o(external_tick_mode_o)
);

// >>> verif/rtc_bus_master.sv
`timescale 1ns/100ps
// ----
// Two-wire bus master model.
// ----
module rtc_bus_master
(
	input wire logic core_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// Bus idles with both lines high.
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// A quarter bit is ten core cycles, far above the pin sync delay.
	task automatic q();
		repeat (10) @(posedge core_clk_i);
		#1;
	endtask

	task automatic start();
		sda_low_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_low_o = 1'b1;
		q();
		scl_o = 1'b0;
		q();
	endtask

	task automatic stop();
		sda_low_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_low_o = 1'b0;
		q();
	endtask

	// data moves only while the clock is low.
	task automatic bitx(input logic b, output logic r);
		sda_low_o = !b;
		q();
		scl_o = 1'b1;
		q();
		r = sda_i;
		q();
		scl_o = 1'b0;
		q();
	endtask

	// eight bits then an acknowledge slot.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask

	// acknowledge all but the last byte.
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
endmodule

// >>> verif/tb_rtc_i2c_slave_test_logic.sv
`timescale 1ns/100ps
module tb_rtc_i2c_slave_test_logic;
	import rtc_pkg::*;
	// ----
	// Signals and counters.
	// ----
	localparam int POR = 2000;
	localparam logic [6:0] ADDR = 7'h2A;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ovr = 1'b0;
	logic tick = 1'b0;
	logic tb_pin = 1'b0;
	logic scl, m_low, sda_o, sda_oe, pin_o, pin_oe, sec_inc, por, omode, xmode, ack;
	// Open-drain data line with pull-up.
	wire sda = !(m_low || (sda_oe && !sda_o));
	wire pin_w = pin_oe ? pin_o : tb_pin;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int secs = 0;
	rtc_byte_t rb;

	always #5 core_clk_i = ~core_clk_i;

	rtc_i2c_slave_test_logic #(.SLAVE_ADDR(ADDR), .POR_CYCLES(POR)) u_dut (.core_clk_i(core_clk_i),
		.srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.clock_output_pin_i(pin_w), .clock_output_pin_o(pin_o), .clock_output_pin_oe_o(pin_oe),
		.int_tick_i(tick), .override_seq_i(ovr), .sec_inc_o(sec_inc), .por_active_o(por),
		.override_mode_o(omode), .external_tick_mode_o(xmode));
	rtc_bus_master u_m (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

	// Seconds pulses and the hang limit.
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (sec_inc === 1'b1)
			secs++;
		if (cyc == 60000)
		begin
			errors++;
			summarize();
		end
	end

	// ----
	// Shared tasks.
	// ----
	task automatic summarize();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cw(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wr(input rtc_byte_t b[$], input logic exp);
		u_m.start();
		u_m.wr_byte({ADDR, 1'b0}, ack);
		cmp("addr ack", exp, ack);
		foreach (b[i])
		begin
			u_m.wr_byte(b[i], ack);
			cmp("data ack", exp, ack);
		end
		u_m.stop();
	endtask

	// Pointer write, repeated start, then a read of e.size() bytes.
	task automatic rd(input rtc_byte_t ptr, input rtc_byte_t e[$]);
		u_m.start();
		u_m.wr_byte({ADDR, 1'b0}, ack);
		u_m.wr_byte(ptr, ack);
		u_m.start();
		u_m.wr_byte({ADDR, 1'b1}, ack);
		cmp("read ack", 1'b1, ack);
		foreach (e[i])
		begin
			u_m.rd_byte(i == e.size() - 1, rb);
			cmp("read byte", e[i], rb);
		end
		u_m.stop();
	endtask

	// The pin clock runs unrelated to the core clock, only in bursts.
	task automatic ext_ticks(input int n);
		repeat (n)
		begin
			tb_pin = 1'b1;
			#62.5;
			tb_pin = 1'b0;
			#62.5;
		end
		cw(8);
	endtask

	task automatic pulse_ovr();
		ovr = 1'b1;
		cw(10);
		ovr = 1'b0;
		cw(10);
	endtask

	// ----
	// Scenarios.
	// ----
	task automatic t_por();
		cmp("por at reset", 1'b1, por);
		cw(POR + 10);
		cmp("por expired", 1'b0, por);
		srst_i = 1'b1;
		cw(3);
		srst_i = 1'b0;
		cw(3);
		wr('{8'h00}, 1'b0);
		pulse_ovr();
		cmp("por override", 1'b0, por);
		cmp("override mode", 1'b1, omode);
	endtask

	task automatic t_addr();
		u_m.start();
		u_m.wr_byte({7'h2B, 1'b0}, ack);
		cmp("foreign addr", 1'b0, ack);
		u_m.stop();
		wr('{8'hF3, 8'hA5}, 1'b1);
		rd(8'hE3, '{8'hA5});
	endtask

	// tester steps: test on, hold set and cleared, time loaded.
	task automatic t_test();
		wr('{8'h00, 8'hA8}, 1'b1);
		cmp("test mode", 1'b1, xmode);
		cmp("pin as input", 1'b0, pin_oe);
		secs = 0;
		ext_ticks(40);
		cmp("held count", 8'h00, secs[7:0]);
		wr('{8'h00, 8'h88}, 1'b1);
		rd(8'h00, '{8'h88});
		wr('{8'h02, 8'h05, 8'h5A}, 1'b1);
		ext_ticks(31);
		cmp("31 edges", 8'h00, secs[7:0]);
		ext_ticks(1);
		cmp("32 edges", 8'h01, secs[7:0]);
		ext_ticks(63);
		cmp("95 edges", 8'h01, secs[7:0]);
		ext_ticks(1);
		cmp("96 edges", 8'h02, secs[7:0]);
		rd(8'h02, '{8'h07, 8'h5A});
	endtask

	task automatic t_permit();
		wr('{8'h00, 8'h80}, 1'b1);
		cmp("mode left", 1'b0, omode);
		cmp("no reset", 1'b0, por);
		cmp("test kept", 1'b1, xmode);
		pulse_ovr();
		cmp("entry blocked", 1'b0, omode);
		wr('{8'h00, 8'h28}, 1'b1);
		cmp("pin driven", 1'b1, pin_oe);
		wr('{8'h00, 8'h08}, 1'b1);
		pulse_ovr();
		cmp("re-entry", 1'b1, omode);
		secs = 0;
		repeat (32)
		begin
			tick = 1'b1;
			cw(1);
			tick = 1'b0;
			cw(3);
		end
		cw(4);
		cmp("internal tick", 8'h01, secs[7:0]);
		// In normal mode the pin shows the lowest pre-scaler stage.
		cmp("pin even", 1'b0, pin_o);
		tick = 1'b1;
		cw(1);
		tick = 1'b0;
		cw(4);
		cmp("pin odd", 1'b1, pin_o);
	endtask

	initial
	begin
		cw(20);
		srst_i = 1'b0;
		cw(2);
		t_por();
		t_addr();
		t_test();
		t_permit();
		summarize();
	end
endmodule
